// >>> core/psd_params.svh
// Register indices, field positions, masks and reset values of the pin sharing block
`ifndef PSD_PARAMS_SVH
`define PSD_PARAMS_SVH

// Register indices; the byte address on the bus is four times the index
`define PSD_IDX_SEL0       30'h0000_ff00
`define PSD_IDX_SEL1       30'h0000_ff01
`define PSD_IDX_SEL2       30'h0000_ff02
`define PSD_IDX_P5DIR      30'h0000_ff03
`define PSD_IDX_P6DIR      30'h0000_ff04
`define PSD_IDX_P7DIR      30'h0000_ff05

// Implemented bits of each register
`define PSD_MASK_SEL0      8'h7f
`define PSD_MASK_SEL1      8'hc7
`define PSD_MASK_SEL2      8'h1f
`define PSD_MASK_P5DIR     8'hff
`define PSD_MASK_P6DIR     8'hff
`define PSD_MASK_P7DIR     8'hc0

// Reset values
`define PSD_RST_SEL0       8'h40
`define PSD_RST_SEL1       8'h45
`define PSD_RST_SEL2       8'h00
`define PSD_RST_P5DIR      8'h00
`define PSD_RST_P6DIR      8'h00
`define PSD_RST_P7DIR      8'h00

// Field positions
`define PSD_B_SECOND_PAIR  6
`define PSD_B_ANALOG_PAIR  7
`define PSD_B_DIGITAL_PAIR 6
`define PSD_B_IRQ1_CONNECT 2
`define PSD_B_CLKOUT_TWO   1
`define PSD_B_FIRST_PAIR   0
`define PSD_B_CLKOUT_ONE   4
`define PSD_B_P7_BIT6      6

// Bus responses
`define PSD_RESP_OKAY      2'h0
`define PSD_RESP_SLVERR    2'h2

`endif

// >>> core/psd_pkg.sv
// Types shared by the pin sharing block
package psd_pkg;

  // One eight-pin pad group: level driven and drive enable
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } psd_pad8_s;

  // Serial channel pair: as an input the line levels, as a drive the pull-low requests
  typedef struct packed {
    logic clk;
    logic data;
  } psd_chan_s;

endpackage : psd_pkg

// >>> core/psd_pin_mux.sv
// Pin function selection and port 5/6/7 direction control behind an AXI4-Lite slave
`timescale 1ns/100ps
`default_nettype none
`include "psd_params.svh"

// Function
// - Select0 bit 6, reset 1, puts second serial pair on pins 5.6/5.7.
// - Select0 bits 5:0, reset 0, put pulse output n onto pin 5.n.
// - Select1 bit 7, reset 0, moves analog channel from first to second pair.
// - Select1 bit 6, reset 1, moves digital channel to second pair when set.
// - Select1 bit 2, reset 1, connects pin 3.3 to interrupt one input.
// - Select1 bit 1, reset 0, drives clock output two onto pin 7.6.
// - Select1 bit 0, reset 1, puts first serial pair on pins 3.0/3.1.
// - Select2 bit 4, reset 0, drives clock output one onto pin 6.6.
// - Select2 bits 3:0, reset 0, connect analog input n to pin 6.n.
// - Port 5 direction register, one bit per pin, 1 is output, reset 0.
// - Port 6 direction register, one bit per pin, 1 is output, reset 0.
// - Port 7 direction holds only bits 7 and 6, reset 0; rest reserved.
module psd_pin_mux (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [31:0]         s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [31:0]         s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire logic [5:0]          pulse_out,
  input  wire logic                clock_output_one,
  input  wire logic                clock_output_two,
  input  wire psd_pkg::psd_chan_s  analog_chan_drive,
  input  wire psd_pkg::psd_chan_s  digital_chan_drive,
  input  wire logic [7:0]          port5_out,
  input  wire logic [7:0]          port6_out,
  input  wire logic [1:0]          port7_out,
  input  wire logic [2:0]          port3_out,
  input  wire logic [2:0]          port3_oe,
  input  wire logic [7:0]          p5_pad_in,
  input  wire logic [7:0]          p6_pad_in,
  input  wire logic [1:0]          p7_pad_in,
  input  wire logic [2:0]          p3_pad_in,
  output psd_pkg::psd_pad8_s       p5_pad,
  output psd_pkg::psd_pad8_s       p6_pad,
  output logic [1:0]               p7_pad_out,
  output logic [1:0]               p7_pad_oe,
  output logic [2:0]               p3_pad_out,
  output logic [2:0]               p3_pad_oe,
  output logic [7:0]               port5_in,
  output logic [7:0]               port6_in,
  output logic [1:0]               port7_in,
  output logic [2:0]               port3_in,
  output psd_pkg::psd_chan_s       analog_chan_in,
  output psd_pkg::psd_chan_s       digital_chan_in,
  output logic [3:0]               analog_in_route,
  output logic                     external_interrupt_one
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0]  pin_function_select_0;
  logic [7:0]  pin_function_select_1;
  logic [7:0]  pin_function_select_2;
  logic [7:0]  port5_direction;
  logic [7:0]  port6_direction;
  logic [7:0]  port7_direction;

  logic        aw_held;
  logic        w_held;
  logic [29:0] wr_index;
  logic [7:0]  wr_data;
  logic        wr_lane0;
  logic        do_write;
  logic        wr_hit;

  function automatic logic index_mapped(input logic [29:0] idx);
    index_mapped = (idx == `PSD_IDX_SEL0) || (idx == `PSD_IDX_SEL1) ||
                   (idx == `PSD_IDX_SEL2) || (idx == `PSD_IDX_P5DIR) ||
                   (idx == `PSD_IDX_P6DIR) || (idx == `PSD_IDX_P7DIR);
  endfunction : index_mapped

  function automatic logic [7:0] read_value(input logic [29:0] idx,
                                            input logic [7:0]  s0,
                                            input logic [7:0]  s1,
                                            input logic [7:0]  s2,
                                            input logic [7:0]  d5,
                                            input logic [7:0]  d6,
                                            input logic [7:0]  d7);
    read_value = 8'h00;
    if (idx == `PSD_IDX_SEL0) read_value = s0;
    if (idx == `PSD_IDX_SEL1) read_value = s1;
    if (idx == `PSD_IDX_SEL2) read_value = s2;
    if (idx == `PSD_IDX_P5DIR) read_value = d5;
    if (idx == `PSD_IDX_P6DIR) read_value = d6;
    if (idx == `PSD_IDX_P7DIR) read_value = d7;
  endfunction : read_value

  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign wr_hit   = do_write && wr_lane0;

  ////////////////////////////////////////////////////////////////////////////
  // Write channels: address and data are taken in either order

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      wr_index      <= 30'h0000_0000;
      wr_data       <= 8'h00;
      wr_lane0      <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PSD_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held       <= 1'b1;
        wr_index      <= s_axi_awaddr[31:2];
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held       <= 1'b1;
        wr_data      <= s_axi_wdata[7:0];
        wr_lane0     <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= index_mapped(wr_index) ? `PSD_RESP_OKAY : `PSD_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel: one cycle from address to data

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `PSD_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {24'h00_0000, read_value(s_axi_araddr[31:2],
                                                  pin_function_select_0,
                                                  pin_function_select_1,
                                                  pin_function_select_2,
                                                  port5_direction,
                                                  port6_direction,
                                                  port7_direction)};
        s_axi_rresp   <= index_mapped(s_axi_araddr[31:2]) ? `PSD_RESP_OKAY
                                                          : `PSD_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register storage; masks keep reserved bits at zero

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_function_select_0 <= `PSD_RST_SEL0;
      pin_function_select_1 <= `PSD_RST_SEL1;
      pin_function_select_2 <= `PSD_RST_SEL2;
      port5_direction       <= `PSD_RST_P5DIR;
      port6_direction       <= `PSD_RST_P6DIR;
      port7_direction       <= `PSD_RST_P7DIR;
    end else if (wr_hit) begin
      if (wr_index == `PSD_IDX_SEL0)
        pin_function_select_0 <= wr_data & `PSD_MASK_SEL0;
      if (wr_index == `PSD_IDX_SEL1)
        pin_function_select_1 <= wr_data & `PSD_MASK_SEL1;
      if (wr_index == `PSD_IDX_SEL2)
        pin_function_select_2 <= wr_data & `PSD_MASK_SEL2;
      if (wr_index == `PSD_IDX_P5DIR)
        port5_direction <= wr_data & `PSD_MASK_P5DIR;
      if (wr_index == `PSD_IDX_P6DIR)
        port6_direction <= wr_data & `PSD_MASK_P6DIR;
      if (wr_index == `PSD_IDX_P7DIR)
        port7_direction <= wr_data & `PSD_MASK_P7DIR;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pad input synchronisers: three stages, a change counts once stages two
  // and three agree, which also rejects single-cycle glitches

  logic [20:0] pad_raw;
  logic [20:0] sync1;
  logic [20:0] sync2;
  logic [20:0] sync3;
  logic [20:0] pad_level;

  assign pad_raw = {p3_pad_in, p7_pad_in, p6_pad_in, p5_pad_in};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1     <= 21'h1f_ffff;
      sync2     <= 21'h1f_ffff;
      sync3     <= 21'h1f_ffff;
      pad_level <= 21'h1f_ffff;
    end else begin
      sync1     <= pad_raw;
      sync2     <= sync1;
      sync3     <= sync2;
      pad_level <= (sync2 & sync3) | (pad_level & (sync2 ^ sync3));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin routing

  logic               second_serial_pair_sel;
  logic [5:0]         pulse_sel;
  logic               analog_channel_pair_sel;
  logic               digital_channel_pair_sel;
  logic               ext_irq1_pin_connect;
  logic               clock_out_two_sel;
  logic               first_serial_pair_sel;
  logic               clock_out_one_sel;
  logic [3:0]         analog_sel;
  psd_pkg::psd_chan_s first_pair_pull;
  psd_pkg::psd_chan_s second_pair_pull;
  psd_pkg::psd_chan_s first_pair_level;
  psd_pkg::psd_chan_s second_pair_level;
  psd_pkg::psd_pad8_s next_p5_pad;
  psd_pkg::psd_pad8_s next_p6_pad;
  logic [1:0]         next_p7_out;
  logic [1:0]         next_p7_oe;
  logic [2:0]         next_p3_out;
  logic [2:0]         next_p3_oe;

  assign second_serial_pair_sel   = pin_function_select_0[`PSD_B_SECOND_PAIR];
  assign pulse_sel                = pin_function_select_0[5:0];
  assign analog_channel_pair_sel  = pin_function_select_1[`PSD_B_ANALOG_PAIR];
  assign digital_channel_pair_sel = pin_function_select_1[`PSD_B_DIGITAL_PAIR];
  assign ext_irq1_pin_connect     = pin_function_select_1[`PSD_B_IRQ1_CONNECT];
  assign clock_out_two_sel        = pin_function_select_1[`PSD_B_CLKOUT_TWO];
  assign first_serial_pair_sel    = pin_function_select_1[`PSD_B_FIRST_PAIR];
  assign clock_out_one_sel        = pin_function_select_2[`PSD_B_CLKOUT_ONE];
  assign analog_sel               = pin_function_select_2[3:0];

  // Serial lines are open drain: a channel only ever pulls its pair low
  always_comb begin
    first_pair_pull.clk   = (!analog_channel_pair_sel && analog_chan_drive.clk) ||
                            (!digital_channel_pair_sel && digital_chan_drive.clk);
    first_pair_pull.data  = (!analog_channel_pair_sel && analog_chan_drive.data) ||
                            (!digital_channel_pair_sel && digital_chan_drive.data);
    second_pair_pull.clk  = (analog_channel_pair_sel && analog_chan_drive.clk) ||
                            (digital_channel_pair_sel && digital_chan_drive.clk);
    second_pair_pull.data = (analog_channel_pair_sel && analog_chan_drive.data) ||
                            (digital_channel_pair_sel && digital_chan_drive.data);
    // A pair not routed to its pins reads idle high
    first_pair_level.clk   = first_serial_pair_sel ? pad_level[18] : 1'b1;
    first_pair_level.data  = first_serial_pair_sel ? pad_level[19] : 1'b1;
    second_pair_level.clk  = second_serial_pair_sel ? pad_level[6] : 1'b1;
    second_pair_level.data = second_serial_pair_sel ? pad_level[7] : 1'b1;
  end

  always_comb begin
    next_p5_pad.out = port5_out;
    next_p5_pad.oe  = port5_direction;
    for (int i = 0; i < 6; i++) begin
      if (pulse_sel[i]) begin
        next_p5_pad.out[i] = pulse_out[i];
        next_p5_pad.oe[i]  = 1'b1;
      end
    end
    if (second_serial_pair_sel) begin
      next_p5_pad.out[7:6] = 2'h0;
      next_p5_pad.oe[6]    = second_pair_pull.clk;
      next_p5_pad.oe[7]    = second_pair_pull.data;
    end

    next_p6_pad.out = port6_out;
    next_p6_pad.oe  = port6_direction;
    for (int i = 0; i < 4; i++) begin
      if (analog_sel[i]) begin
        next_p6_pad.out[i] = 1'b0;
        next_p6_pad.oe[i]  = 1'b0;
      end
    end
    if (clock_out_one_sel) begin
      next_p6_pad.out[6] = clock_output_one;
      next_p6_pad.oe[6]  = 1'b1;
    end

    // Bit 0 here is pin 7.6, bit 1 is pin 7.7
    next_p7_out = port7_out;
    next_p7_oe  = port7_direction[7:6];
    if (clock_out_two_sel) begin
      next_p7_out[0] = clock_output_two;
      next_p7_oe[0]  = 1'b1;
    end

    // Bits are pins 3.0, 3.1 and 3.3; port mode keeps receive and transmit
    next_p3_out = port3_out;
    next_p3_oe  = port3_oe;
    if (first_serial_pair_sel) begin
      next_p3_out[1:0] = 2'h0;
      next_p3_oe[0]    = first_pair_pull.clk;
      next_p3_oe[1]    = first_pair_pull.data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      p5_pad          <= '0;
      p6_pad          <= '0;
      p7_pad_out      <= 2'h0;
      p7_pad_oe       <= 2'h0;
      p3_pad_out      <= 3'h0;
      p3_pad_oe       <= 3'h0;
      analog_chan_in  <= 2'h3;
      digital_chan_in <= 2'h3;
      analog_in_route <= 4'h0;
    end else begin
      p5_pad          <= next_p5_pad;
      p6_pad          <= next_p6_pad;
      p7_pad_out      <= next_p7_out;
      p7_pad_oe       <= next_p7_oe;
      p3_pad_out      <= next_p3_out;
      p3_pad_oe       <= next_p3_oe;
      analog_chan_in  <= analog_channel_pair_sel ? second_pair_level
                                                 : first_pair_level;
      digital_chan_in <= digital_channel_pair_sel ? second_pair_level
                                                  : first_pair_level;
      analog_in_route <= analog_sel;
    end
  end

  // Port input values are always the filtered pad levels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port5_in <= 8'hff;
      port6_in <= 8'hff;
      port7_in <= 2'h3;
      port3_in <= 3'h7;
    end else begin
      port5_in <= pad_level[7:0];
      port6_in <= pad_level[15:8];
      port7_in <= pad_level[17:16];
      port3_in <= pad_level[20:18];
    end
  end

  // Interrupt input is active low, so a disconnected pin reads inactive high;
  // software must disconnect it while pin 3.3 serves as general purpose
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      external_interrupt_one <= 1'b1;
    end else begin
      external_interrupt_one <= ext_irq1_pin_connect ? pad_level[20] : 1'b1;
    end
  end

endmodule : psd_pin_mux
`default_nettype wire

// >>> tb/psd_board.sv
// Board model for the pin sharing block: pull-ups and outside parties on each pad
`timescale 1ns/100ps
`default_nettype none
module psd_board (
  input  wire psd_pkg::psd_pad8_s p5_pad,
  input  wire psd_pkg::psd_pad8_s p6_pad,
  input  wire logic [1:0]         p7_pad_out,
  input  wire logic [1:0]         p7_pad_oe,
  input  wire logic [2:0]         p3_pad_out,
  input  wire logic [2:0]         p3_pad_oe,
  input  wire logic [20:0]        ext,
  output logic [7:0]              p5_pad_in,
  output logic [7:0]              p6_pad_in,
  output logic [1:0]              p7_pad_in,
  output logic [2:0]              p3_pad_in
);
  // Wired-AND: a released pad floats high on its pull-up
  assign p5_pad_in = ext[20:13] & (~p5_pad.oe | p5_pad.out);
  assign p6_pad_in = ext[12:5] & (~p6_pad.oe | p6_pad.out);
  assign p7_pad_in = ext[4:3] & (~p7_pad_oe | p7_pad_out);
  assign p3_pad_in = ext[2:0] & (~p3_pad_oe | p3_pad_out);
endmodule : psd_board
`default_nettype wire

// >>> tb/psd_pin_mux_asserts.sv
// Concurrent checks on the pin sharing block ports
`timescale 1ns/100ps
`default_nettype none
module psd_pin_mux_asserts (
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_wready,
  input wire logic [1:0]         s_axi_bresp,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_bready,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic [31:0]        s_axi_rdata,
  input wire logic               s_axi_rvalid,
  input wire logic               s_axi_rready,
  input wire logic [3:0]         analog_in_route,
  input wire psd_pkg::psd_pad8_s p6_pad
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write response late");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  wr_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  wr_reopen_a: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid && s_axi_awready && s_axi_wready) else $error("write not reopened");
  rd_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  analog_quiet_a: assert property ((analog_in_route & $past(analog_in_route)
    & p6_pad.oe[3:0]) == 4'h0) else $error("analog input pin driven");
  cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h2);
  cover property (s_axi_rvalid && !s_axi_rready);
  cover property (analog_in_route == 4'hf);
endmodule : psd_pin_mux_asserts
`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench for the pin sharing block
`timescale 1ns/100ps
`default_nettype none
`include "psd_params.svh"
module tb;
  logic               aclk = '0, aresetn = '0, s_axi_awvalid = '0, s_axi_wvalid = '0;
  logic               s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
  logic [31:0]        s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
  logic [3:0]         s_axi_wstrb = '0, analog_in_route;
  logic               s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]         s_axi_bresp, s_axi_rresp, p7_pad_out, p7_pad_oe, p7_pad_in, port7_in;
  logic [5:0]         pulse_out = '0;
  logic               clock_output_one = '0, clock_output_two = '0, external_interrupt_one;
  psd_pkg::psd_chan_s analog_chan_drive = '0, digital_chan_drive = '0;
  psd_pkg::psd_chan_s analog_chan_in, digital_chan_in;
  logic [7:0]         port5_out = '0, port6_out = '0, p5_pad_in, p6_pad_in, port5_in, port6_in;
  logic [1:0]         port7_out = '0;
  logic [2:0]         port3_out = '0, port3_oe = '0, p3_pad_in, p3_pad_out, p3_pad_oe, port3_in;
  logic [20:0]        ext = '1;
  psd_pkg::psd_pad8_s p5_pad, p6_pad;
  logic [31:0]        seed = 32'h0001_3775;
  logic [7:0]         v;
  logic [7:0]         m [6];
  logic [29:0]        idx_t [6] = '{`PSD_IDX_SEL0, `PSD_IDX_SEL1, `PSD_IDX_SEL2,
                                    `PSD_IDX_P5DIR, `PSD_IDX_P6DIR, `PSD_IDX_P7DIR};
  logic [7:0]         mask_t [6] = '{`PSD_MASK_SEL0, `PSD_MASK_SEL1, `PSD_MASK_SEL2,
                                     `PSD_MASK_P5DIR, `PSD_MASK_P6DIR, `PSD_MASK_P7DIR};
  logic [7:0]         rst_t [6] = '{`PSD_RST_SEL0, `PSD_RST_SEL1, `PSD_RST_SEL2,
                                    `PSD_RST_P5DIR, `PSD_RST_P6DIR, `PSD_RST_P7DIR};
  int                 bad_count = 0, tests_run = 0, lag = 0;

  always #10 aclk = ~aclk;

  psd_pin_mux i_psd_pin_mux (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .pulse_out, .clock_output_one, .clock_output_two,
    .analog_chan_drive, .digital_chan_drive, .port5_out, .port6_out, .port7_out, .port3_out,
    .port3_oe, .p5_pad_in, .p6_pad_in, .p7_pad_in, .p3_pad_in, .p5_pad, .p6_pad, .p7_pad_out,
    .p7_pad_oe, .p3_pad_out, .p3_pad_oe, .port5_in, .port6_in, .port7_in, .port3_in,
    .analog_chan_in, .digital_chan_in, .analog_in_route, .external_interrupt_one);
  psd_board i_psd_board (.p5_pad, .p6_pad, .p7_pad_out, .p7_pad_oe, .p3_pad_out, .p3_pad_oe,
    .ext, .p5_pad_in, .p6_pad_in, .p7_pad_in, .p3_pad_in);

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic hang();
    bad_count++;
    $display("mismatch at %0t: bus timeout", $time);
    conclude();
  endtask : hang

  // Ready is raised after a random lag so the slave must hold its answer
  task automatic wr(input logic [29:0] idx, input logic [7:0] d, input logic [3:0] st,
                    input logic [1:0] er);
    logic [31:0] r;
    logic        b;
    r = rnd();
    b = 1'b0;
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= {r[23:0], d};
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (int n = 0; n < 64 && !b; n++) begin
      @(posedge aclk);
      if (n == lag) s_axi_bready <= 1'b1;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bready && s_axi_bvalid) begin
        b = 1'b1;
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er, "bresp");
      end
    end
    if (!b) hang();
  endtask : wr

  task automatic rd(input logic [29:0] idx, input logic [7:0] exp, input logic [1:0] er);
    logic b;
    b = 1'b0;
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    for (int n = 0; n < 64 && !b; n++) begin
      @(posedge aclk);
      if (n == lag) s_axi_rready <= 1'b1;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rready && s_axi_rvalid) begin
        b = 1'b1;
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, {24'h00_0000, exp}, "rdata");
        chk(s_axi_rresp, er, "rresp");
      end
    end
    if (!b) hang();
  endtask : rd

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check_pins();
    logic [7:0] o5, e5, o6, e6, l5, l6;
    logic [1:0] o7, e7, l7, fp, sp, fi, se;
    logic [2:0] o3, e3, l3;
    repeat (8) @(posedge aclk);
    fp = ({2{~m[1][7]}} & analog_chan_drive) | ({2{~m[1][6]}} & digital_chan_drive);
    sp = ({2{m[1][7]}} & analog_chan_drive) | ({2{m[1][6]}} & digital_chan_drive);
    o5 = {m[0][6] ? 2'h0 : port5_out[7:6], (m[0][5:0] & pulse_out) | (~m[0][5:0] & port5_out[5:0])};
    e5 = {m[0][6] ? {sp[0], sp[1]} : m[3][7:6], m[0][5:0] | m[3][5:0]};
    o6 = port6_out & {4'hf, ~m[2][3:0]};
    e6 = m[4] & {4'hf, ~m[2][3:0]};
    o6[6] = m[2][4] ? clock_output_one : o6[6];
    e6[6] = m[2][4] | e6[6];
    o7 = {port7_out[1], m[1][1] ? clock_output_two : port7_out[0]};
    e7 = {m[5][7], m[1][1] | m[5][6]};
    o3 = {port3_out[2], m[1][0] ? 2'h0 : port3_out[1:0]};
    e3 = {port3_oe[2], m[1][0] ? {fp[0], fp[1]} : port3_oe[1:0]};
    l5 = ext[20:13] & (~e5 | o5);
    l6 = ext[12:5] & (~e6 | o6);
    l7 = ext[4:3] & (~e7 | o7);
    l3 = ext[2:0] & (~e3 | o3);
    fi = m[1][0] ? {l3[0], l3[1]} : 2'h3;
    se = m[0][6] ? {l5[6], l5[7]} : 2'h3;
    chk({p5_pad, p6_pad}, {o5, e5, o6, e6}, "p5 p6 drive");
    chk({p7_pad_out, p7_pad_oe, p3_pad_out, p3_pad_oe}, {o7, e7, o3, e3}, "p7 p3 drive");
    chk({port5_in, port6_in, port7_in, port3_in}, {l5, l6, l7, l3}, "pad levels");
    chk({analog_chan_in, digital_chan_in, analog_in_route},
        {m[1][7] ? se : fi, m[1][6] ? se : fi, m[2][3:0]}, "channels");
    chk(external_interrupt_one, m[1][2] ? l3[2] : 1'h1, "interrupt");
  endtask : check_pins

  task automatic stir();
    logic [31:0] a, b;
    a = rnd();
    b = rnd();
    @(posedge aclk);
    pulse_out <= a[5:0];
    clock_output_one <= a[6];
    clock_output_two <= a[7];
    analog_chan_drive <= a[9:8];
    digital_chan_drive <= a[11:10];
    port5_out <= a[19:12];
    port6_out <= a[27:20];
    port7_out <= a[29:28];
    port3_out <= b[2:0];
    port3_oe <= b[5:3];
    ext <= b[26:6];
    lag = int'(b[31:30]) % 3;
  endtask : stir

  task automatic reset_check();
    aresetn <= '0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    for (int k = 0; k < 6; k++) begin
      m[k] = rst_t[k];
      rd(idx_t[k], rst_t[k], 2'h0);
    end
    check_pins();
    $display("reset checked");
  endtask : reset_check

  initial begin
    reset_check();
    rd(30'h0000_ff06, 8'h00, 2'h2);
    wr(30'h0000_ff06, 8'hff, 4'h1, 2'h2);
    wr(`PSD_IDX_SEL2, 8'hff, 4'h0, 2'h0);
    rd(`PSD_IDX_SEL2, `PSD_RST_SEL2, 2'h0);
    $display("refused checked");
    for (int it = 0; it < 40; it++) begin
      stir();
      for (int k = 0; k < 6; k++) begin
        v = (it == 0) ? 8'hff : (it == 1) ? 8'h00 : 8'(rnd());
        if (k == 1 && port3_oe[2]) v[2] = 1'h0;
        wr(idx_t[k], v, 4'h1, 2'h0);
        m[k] = v & mask_t[k];
        rd(idx_t[k], m[k], 2'h0);
      end
      check_pins();
    end
    $display("routing checked");
    reset_check();
    conclude();
  end
endmodule : tb

bind psd_pin_mux psd_pin_mux_asserts i_psd_pin_mux_asserts (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .analog_in_route, .p6_pad);
`default_nettype wire
